// File: iopsc_consts.vh
`ifndef IOPSC_CONSTS_VH
`define IOPSC_CONSTS_VH
// Register addresses
`define IOPSC_ADDR_PA_DATA 8'h12
`define IOPSC_ADDR_PA_DIR 8'h13
`define IOPSC_ADDR_PB_DATA 8'h14
`define IOPSC_ADDR_PB_DIR 8'h15
`define IOPSC_ADDR_SW_LO 8'h1A
`define IOPSC_ADDR_SW_HI 8'h1B
`define IOPSC_ADDR_PULLLOW 8'h1C
// Reset values
`define IOPSC_RST_DIR 8'hFF
`define IOPSC_RST_DATA 8'h00
`define IOPSC_RST_SW 8'hFF
`define IOPSC_RST_PULLLOW 6'h00
`define IOPSC_RST_SW_HI 4'hF
`define IOPSC_RST_PULL 8'h00
`define IOPSC_RST_SENSOR 12'h000
`define IOPSC_RST_WAKE_ARM 2'h0
// Timing counts
`define IOPSC_WAKE_ARM_DONE 2'h3
// Field masks and widths
`define IOPSC_SW_HI_MASK 8'h0F
`define IOPSC_PULLLOW_W 6
`endif

// File: iopsc_pin_model.sv
`timescale 1ns/1ps
// Outside of one port: outside drivers, pull-highs and floating lines
module iopsc_pin_model
(
   // Clock
   input wire clk_i,
   // Port side
   input wire [7:0] out_i,
   input wire [7:0] oe_n_i,
   input wire [7:0] pullhigh_i,
   // Outside drivers
   input wire [7:0] ext_i,
   input wire [7:0] ext_en_i,
   // Resolved pad level
   output wire [7:0] pad_o
);
   reg [7:0] float_reg = 8'h5A; // Undriven lines without pull-high wander every cycle
   // Toggle so a floating line never looks stable
   always @(posedge clk_i)
   begin
      float_reg <= ~float_reg;
   end
   // Port drives first, then outside, then pull-high
   assign pad_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_i)
      | (oe_n_i & ~ext_en_i & (pullhigh_i | float_reg));
endmodule

// File: iopsc_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser for an 8-bit pin group
module iopsc_sync2
(
   // Clock and reset
   input wire clk_i,
   input wire resetn_i,
   // Data
   input wire [7:0] d_i,
   output reg [7:0] q_o
);
   reg [7:0] meta_reg; // First stage, read only by the second

   // Two register stages
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_reg <= 8'h00;
         q_o <= 8'h00;
      end
      else
      begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule

// File: iopsc_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench of the port block
module iopsc_tb_top;
   reg clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   reg [7:0] addr_i = 8'h00, wdata_i = 8'h00;
   reg [7:0] sens = 8'h00, wk = 8'h00, pha = 8'h00, phb = 8'h00; // Straps
   reg [7:0] xa = 8'h00, xb = 8'h00, ea = 8'h00, eb = 8'h00; // Outside drive
   reg [7:0] v, lo, hi, pw;
   wire [7:0] rdata_o, pa_i, pb_i, pa_o, pa_n, pa_h, pb_o, pb_n, pb_h;
   wire [11:0] son, spl;
   wire i0, i1, te, wake;
   integer fail_count = 0, cmp_count = 0, i;
   iopsc_top iopsc_top_i (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .opt_pa_sensor_i(sens),
      .opt_pa_wake_i(wk), .opt_pa_pullhigh_i(pha), .opt_pb_pullhigh_i(phb), .pa_in_i(pa_i), .pa_out_o(pa_o),
      .pa_oe_n_o(pa_n), .pa_pullhigh_o(pa_h), .pb_in_i(pb_i), .pb_out_o(pb_o), .pb_oe_n_o(pb_n),
      .pb_pullhigh_o(pb_h), .ext_irq_zero_in_o(i0), .ext_irq_one_in_o(i1), .timer_event_in_o(te),
      .wake_o(wake), .sensor_switch_on_o(son), .sensor_pulllow_o(spl));
   iopsc_pin_model iopsc_pin_model_i (.clk_i, .out_i(pa_o), .oe_n_i(pa_n), .pullhigh_i(pa_h), .ext_i(xa),
      .ext_en_i(ea), .pad_o(pa_i));
   iopsc_pin_model iopsc_pin_model_b_i (.clk_i, .out_i(pb_o), .oe_n_i(pb_n), .pullhigh_i(pb_h), .ext_i(xb),
      .ext_en_i(eb), .pad_o(pb_i));
   // 40 MHz clock
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   // Masked compare, counted
   task chk(input string n, input [11:0] e, input [11:0] s, input [11:0] m);
   begin
      cmp_count = cmp_count + 1;
      if (((e ^ s) & m) !== 12'h000)
      begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      end
   end
   endtask
   // One-cycle register write
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   end
   endtask
   // One-cycle read, data taken in the next cycle
   task rd(input [7:0] a);
   begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   end
   endtask
   // Expected closed switches
   function [11:0] swx(input [7:0] l, input [7:0] h);
      swx = ~{h[3:0], l} & {sens[7:4], 4'hF, sens[3:0]};
   endfunction
   // Expected pull-lows
   function [11:0] plx(input [11:0] on, input [5:0] p);
      integer k;
   begin
      for (k = 0; k < 12; k = k + 1)
         plx[k] = p[k / 2] & ~on[k];
   end
   endfunction
   // Random direction and latch, read back, then a bit flip
   task port(input [7:0] a, input [7:0] sm, input [7:0] en, input [7:0] x, input [7:0] ph);
      reg [7:0] d, l;
   begin
      d = $urandom;
      l = $urandom;
      wr(a + 8'h01, d);
      wr(a, l);
      repeat (4) @(posedge clk_i);
      rd(a);
      chk("pad read", ((d & (x | ~en)) | (~d & l)) & ~sm, v, ~d | en | ph | sm);
      chk("oe", d | sm, a[2] ? pb_n : pa_n, 8'hFF);
      chk("pullhigh", ph & ~sm, a[2] ? pb_h : pa_h, 8'hFF);
      if (!a[2])
         chk("shared", pa_i, {te, i1, i0}, 8'h07 & en & (d | sm));
      wr(a, v ^ 8'h80);
      repeat (2) @(posedge clk_i);
      chk("rmw out", (v ^ 8'h80) & ~sm, a[2] ? pb_o : pa_o, 8'hFF);
   end
   endtask
   // Wake: quiet while every pad is held, one pulse after all outside drives toggle if a wake-enabled I/O line is an input
   task wake_test(input [7:0] dd);
   begin
      wr(8'h13, dd);
      ea <= 8'hFF;
      repeat (5) @(posedge clk_i);
      #1 chk("wake idle", 12'h000, {11'h000, wake}, 12'h001);
      @(posedge clk_i);
      xa <= ~xa;
      repeat (3) @(posedge clk_i);
      #1 chk("wake pulse", {11'h000, |(dd & ~sens & wk)}, {11'h000, wake}, 12'h001);
      @(posedge clk_i);
      #1 chk("wake end", 12'h000, {11'h000, wake}, 12'h001);
   end
   endtask
   // Counts and verdict
   task stop_test;
   begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   // Main sequence
   initial
   begin
      v = $urandom(32'hFBE25072);
      pw = $urandom;
      sens <= pw;
      // Random wake options, the lowest I/O line always enabled
      wk <= $urandom | (~pw & (pw + 8'h01));
      pha <= $urandom;
      phb <= $urandom;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(8'h13);
      chk("pa dir", ~sens, v, 8'hFF);
      rd(8'h15);
      chk("pb dir", 8'hFF, v, 8'hFF);
      rd(8'h30);
      chk("unmapped", 8'h00, v, 8'hFF);
      for (i = 0; i < 40; i = i + 1)
      begin
         xa <= $urandom;
         xb <= $urandom;
         ea <= $urandom;
         eb <= $urandom;
         @(posedge clk_i);
         port(8'h12, sens, ea, xa, pha);
         wake_test((i == 0) ? 8'hFF : (i == 1) ? 8'h00 : $urandom);
         port(8'h14, 8'h00, eb, xb, phb);
      end
      for (i = 0; i < 20; i = i + 1)
      begin
         lo = (i < 2) ? {8{i[0]}} : $urandom;
         hi = (i < 2) ? {8{i[0]}} : $urandom;
         pw = ((i < 2) ? 8'hFF : $urandom) & {2'b11, &sens[7:6], &sens[5:4], 2'b11, &sens[3:2], &sens[1:0]};
         wr(8'h1A, lo);
         wr(8'h1B, hi);
         wr(8'h1C, pw);
         repeat (2) @(posedge clk_i);
         chk("switch", swx(lo, hi), son, 12'hFFF);
         chk("pull low", plx(swx(lo, hi), pw[5:0]), spl, 12'hFFF);
         rd(8'h1A);
         chk("sw lo rb", {lo[7:4], lo[3:0] & sens[3:0]}, v, 8'hFF);
         rd(8'h1B);
         chk("sw hi rb", hi[3:0] & sens[7:4], v, 8'hFF);
         rd(8'h1C);
         chk("pl rb", pw[5:0], v, 8'hFF);
      end
      // Park every I/O-mode line as an output; sensor-mode PA lines stay undriven
      wr(8'h13, 8'h00);
      wr(8'h15, 8'h00);
      repeat (2) @(posedge clk_i);
      chk("park pa", sens, pa_n, 8'hFF);
      chk("park pb", 8'h00, pb_n, 8'hFF);
      stop_test;
   end
endmodule
bind iopsc_top iopsc_top_assertions iopsc_top_assertions_i (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .opt_pa_sensor_i, .pa_oe_n_o, .pb_out_o, .pb_oe_n_o, .wake_o, .sensor_switch_on_o, .sensor_pulllow_o);

// File: iopsc_top.v
`timescale 1ns/1ps
`include "iopsc_consts.vh"
module iopsc_top
(
   // Clock and reset
   input wire clk_i,
   input wire resetn_i,
   // Register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // Configuration options (static straps)
   input wire [7:0] opt_pa_sensor_i,
   input wire [7:0] opt_pa_wake_i,
   input wire [7:0] opt_pa_pullhigh_i,
   input wire [7:0] opt_pb_pullhigh_i,
   // Port A pins
   input wire [7:0] pa_in_i,
   output reg [7:0] pa_out_o,
   output reg [7:0] pa_oe_n_o,
   output reg [7:0] pa_pullhigh_o,
   // Port B pins
   input wire [7:0] pb_in_i,
   output reg [7:0] pb_out_o,
   output reg [7:0] pb_oe_n_o,
   output reg [7:0] pb_pullhigh_o,
   // Shared-pin functions
   output reg ext_irq_zero_in_o,
   output reg ext_irq_one_in_o,
   output reg timer_event_in_o,
   output reg wake_o,
   // Sensor pad controls, one bit per channel 1-12
   output reg [11:0] sensor_switch_on_o,
   output reg [11:0] sensor_pulllow_o
);
   // Register state
   reg [7:0] pa_data_reg; // Port A output latch
   reg [7:0] pa_dir_reg; // Port A direction, 1 = input
   reg [7:0] pb_data_reg; // Port B output latch
   reg [7:0] pb_dir_reg; // Port B direction, 1 = input
   reg [7:0] sensor_switch_ctrl_lo_reg; // Channels 1-8 switch-off bits
   reg [3:0] sensor_switch_ctrl_hi_reg; // Channels 9-12 switch-off bits
   reg [5:0] sensor_pulllow_ctrl_reg; // Pair pull-low enables
   reg [7:0] rdata_next; // Read mux result
   reg [7:0] pa_pad_last_reg; // Previous synchronised pad state for wake detect
   reg [1:0] wake_arm_reg; // Edges since reset, wake masked until full
   // Synchronised pads
   wire [7:0] pa_pad_sync;
   wire [7:0] pb_pad_sync;
   // Effective values: sensor-mode bits removed from port A, I/O-mode bits from the switch fields
   wire [7:0] pa_io_mask;
   wire [7:0] pa_dir_eff;
   wire [7:0] pa_data_eff;
   wire [7:0] pa_read_val;
   wire [7:0] pb_read_val;
   wire [7:0] sw_lo_eff;
   wire [3:0] sw_hi_eff;
   wire [11:0] sw_off_all;
   wire [11:0] pair_en;
   wire [7:0] pa_wake_change; // Changed I/O input lines with wake enabled
   wire wake_armed; // Synchroniser and history hold real pad data

   // Pad synchronisers
   iopsc_sync2 u_sync_pa
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i(pa_in_i),
      .q_o(pa_pad_sync)
   );
   iopsc_sync2 u_sync_pb
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i(pb_in_i),
      .q_o(pb_pad_sync)
   );

   // Lines in ordinary I/O mode
   assign pa_io_mask = ~opt_pa_sensor_i; // helper
   // Sensor-mode PA bits read and act as zero
   assign pa_dir_eff = pa_dir_reg & pa_io_mask;
   assign pa_data_eff = pa_data_reg & pa_io_mask;
   // Pad for input bits, latch for output bits, sampled at read
   assign pa_read_val = ((pa_pad_sync & pa_dir_eff) | (pa_data_eff & ~pa_dir_eff)) & pa_io_mask;
   assign pb_read_val = (pb_pad_sync & pb_dir_reg) | (pb_data_reg & ~pb_dir_reg);
   // Switch bits of channels 1-4 and 9-12 implemented only for sensor-mode lines
   assign sw_lo_eff = {sensor_switch_ctrl_lo_reg[7:4], sensor_switch_ctrl_lo_reg[3:0] & opt_pa_sensor_i[3:0]};
   assign sw_hi_eff = sensor_switch_ctrl_hi_reg & opt_pa_sensor_i[7:4];
   // Switch-off bits for channels 1-12; an unimplemented bit acts as off
   assign sw_off_all = {sensor_switch_ctrl_hi_reg | ~opt_pa_sensor_i[7:4],
                        sensor_switch_ctrl_lo_reg[7:4],
                        sensor_switch_ctrl_lo_reg[3:0] | ~opt_pa_sensor_i[3:0]};
   // Expand each pair enable to its two channels
   assign pair_en = {{2{sensor_pulllow_ctrl_reg[5]}}, {2{sensor_pulllow_ctrl_reg[4]}},
                     {2{sensor_pulllow_ctrl_reg[3]}}, {2{sensor_pulllow_ctrl_reg[2]}},
                     {2{sensor_pulllow_ctrl_reg[1]}}, {2{sensor_pulllow_ctrl_reg[0]}}};
   // Port A lines that changed, limited to I/O-mode inputs with wake enabled;
   // a direction write alone leaves the pad history alone, so it cannot fake a wake
   assign pa_wake_change = (pa_pad_sync ^ pa_pad_last_reg) & pa_dir_eff & opt_pa_wake_i;
   assign wake_armed = (wake_arm_reg == `IOPSC_WAKE_ARM_DONE);

   // Register writes; latches hold until written again
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pa_data_reg <= `IOPSC_RST_DATA;
         pa_dir_reg <= `IOPSC_RST_DIR;
         pb_data_reg <= `IOPSC_RST_DATA;
         pb_dir_reg <= `IOPSC_RST_DIR;
         sensor_switch_ctrl_lo_reg <= `IOPSC_RST_SW;
         sensor_switch_ctrl_hi_reg <= `IOPSC_RST_SW_HI;
         sensor_pulllow_ctrl_reg <= `IOPSC_RST_PULLLOW;
      end
      else if (wr_i)
      begin
         case (addr_i)
            `IOPSC_ADDR_PA_DATA:
            begin
               pa_data_reg <= wdata_i;
            end
            `IOPSC_ADDR_PA_DIR:
            begin
               pa_dir_reg <= wdata_i;
            end
            `IOPSC_ADDR_PB_DATA:
            begin
               pb_data_reg <= wdata_i;
            end
            `IOPSC_ADDR_PB_DIR:
            begin
               pb_dir_reg <= wdata_i;
            end
            `IOPSC_ADDR_SW_LO:
            begin
               sensor_switch_ctrl_lo_reg <= wdata_i;
            end
            `IOPSC_ADDR_SW_HI:
            begin
               sensor_switch_ctrl_hi_reg <= wdata_i[3:0];
            end
            `IOPSC_ADDR_PULLLOW:
            begin
               sensor_pulllow_ctrl_reg <= wdata_i[5:0];
            end
            default:
            begin
               pa_data_reg <= pa_data_reg; // Unmapped write ignored
            end
         endcase
      end
   end

   // Read mux
   always @*
   begin
      rdata_next = 8'h00;
      case (addr_i)
         `IOPSC_ADDR_PA_DATA: rdata_next = pa_read_val;
         `IOPSC_ADDR_PA_DIR: rdata_next = pa_dir_eff;
         `IOPSC_ADDR_PB_DATA: rdata_next = pb_read_val;
         `IOPSC_ADDR_PB_DIR: rdata_next = pb_dir_reg;
         `IOPSC_ADDR_SW_LO: rdata_next = sw_lo_eff;
         `IOPSC_ADDR_SW_HI: rdata_next = {4'h0, sw_hi_eff};
         `IOPSC_ADDR_PULLLOW: rdata_next = {2'h0, sensor_pulllow_ctrl_reg};
         default: rdata_next = 8'h00; // Unmapped reads return zero
      endcase
   end

   // Read data register, valid the cycle after the strobe only
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (rd_i)
      begin
         rdata_o <= rdata_next;
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

   // Port A pin drivers; sensor-mode lines are never driven
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pa_out_o <= `IOPSC_RST_DATA;
         pa_oe_n_o <= `IOPSC_RST_DIR;
         pa_pullhigh_o <= `IOPSC_RST_PULL;
      end
      else
      begin
         // Drive only I/O-mode lines set as outputs
         pa_out_o <= pa_data_eff;
         pa_oe_n_o <= pa_dir_eff | opt_pa_sensor_i;
         // Pull-high per option, on I/O-mode lines only
         pa_pullhigh_o <= opt_pa_pullhigh_i & pa_io_mask;
      end
   end

   // Port B pin drivers; all eight lines are ordinary I/O
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pb_out_o <= `IOPSC_RST_DATA;
         pb_oe_n_o <= `IOPSC_RST_DIR;
         pb_pullhigh_o <= `IOPSC_RST_PULL;
      end
      else
      begin
         // Latch value, enabled by the direction bit
         pb_out_o <= pb_data_reg;
         pb_oe_n_o <= pb_dir_reg;
         // Pull-high per option
         pb_pullhigh_o <= opt_pb_pullhigh_i;
      end
   end

   // Shared-pin functions follow the synchronised pads whatever the direction,
   // so an output line still feeds its own interrupt or timer input
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ext_irq_zero_in_o <= 1'b0;
         ext_irq_one_in_o <= 1'b0;
         timer_event_in_o <= 1'b0;
      end
      else
      begin
         ext_irq_zero_in_o <= pa_pad_sync[0];
         ext_irq_one_in_o <= pa_pad_sync[1];
         timer_event_in_o <= pa_pad_sync[2];
      end
   end

   // Wake detect: one pulse per cycle with a change on any enabled I/O input line.
   // The arm count masks the first edges after reset, while the synchroniser
   // and the history register still hold reset zeros; otherwise a pad that
   // rests high would raise a false wake just after reset.
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wake_arm_reg <= `IOPSC_RST_WAKE_ARM;
         pa_pad_last_reg <= `IOPSC_RST_DATA;
         wake_o <= 1'b0;
      end
      else
      begin
         // History of every line, direction does not matter here
         pa_pad_last_reg <= pa_pad_sync;
         // Count up to the armed state, then stay there
         if (wake_arm_reg != `IOPSC_WAKE_ARM_DONE)
         begin
            wake_arm_reg <= wake_arm_reg + 2'h1;
         end
         // Pulse only once armed
         wake_o <= wake_armed & (|pa_wake_change);
      end
   end

   // Static sensor pad levels from register state
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sensor_switch_on_o <= `IOPSC_RST_SENSOR;
         sensor_pulllow_o <= `IOPSC_RST_SENSOR;
      end
      else
      begin
         // Closed where the control bit is 0 and the channel is implemented
         sensor_switch_on_o <= ~sw_off_all & {opt_pa_sensor_i[7:4], 4'hF, opt_pa_sensor_i[3:0]};
         // Pulled low where the pair is enabled and the switch is open
         sensor_pulllow_o <= pair_en & sw_off_all;
      end
   end
endmodule

// File: iopsc_top_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the port block
module iopsc_top_assertions
(
   // Clock and reset
   input wire clk_i,
   input wire resetn_i,
   // Register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   // Straps and pad controls
   input wire [7:0] opt_pa_sensor_i,
   input wire [7:0] pa_oe_n_o,
   input wire [7:0] pb_out_o,
   input wire [7:0] pb_oe_n_o,
   input wire wake_o,
   input wire [11:0] sensor_switch_on_o,
   input wire [11:0] sensor_pulllow_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire pbw = wr_i && addr_i == 8'h14; // Port B latch write
   wire [7:0] s = opt_pa_sensor_i; // Sensor straps
   chk_hi_read: assert property ($past(rd_i) && $past(addr_i) == 8'h1B |-> (rdata_o & ~{4'h0, s[7:4]}) == 8'h00)
      else $error("switch hi read bad");
   chk_lo_read: assert property ($past(rd_i) && $past(addr_i) == 8'h1A |-> (rdata_o[3:0] & ~s[3:0]) == 4'h0)
      else $error("switch lo read bad");
   chk_pl_read: assert property ($past(rd_i) && $past(addr_i) == 8'h1C |-> rdata_o[7:6] == 2'b00)
      else $error("pull-low read bad");
   chk_pl_swon: assert property ((sensor_pulllow_o & sensor_switch_on_o) == 12'h000)
      else $error("pull-low on closed switch");
   chk_sw_io: assert property ((sensor_switch_on_o & ~{s[7:4], 4'hF, s[3:0]}) == 12'h000)
      else $error("switch closed on io line");
   chk_oe_sensor: assert property ((s & ~pa_oe_n_o) == 8'h00)
      else $error("sensor line driven");
   chk_pb_write: assert property (pbw |-> ##2 pb_out_o == $past(wdata_i, 2))
      else $error("port b latch write bad");
   chk_pb_hold: assert property (!$past(pbw, 2) |-> $stable(pb_out_o))
      else $error("port b latch moved");
   chk_dir_write: assert property (wr_i && addr_i == 8'h15 |-> ##2 pb_oe_n_o == $past(wdata_i, 2))
      else $error("port b direction bad");
   cover property (pbw);
   cover property (sensor_pulllow_o != 12'h000);
   cover property (sensor_switch_on_o != 12'h000);
   cover property (wake_o);
endmodule
